// file: eit_chan.sv
// One timestamp counter channel with edge detector
`timescale 1ns/100ps
module eit_chan
    import eit_pkg::*;
(
    input  wire logic i_ref_clk, // System clock
    input  wire logic i_rst_n,   // Async reset, active low
    eit_chan_if.cnt   ch         // Channel control and counter
);
    logic                 pin_reg;
    logic [EIT_CNT_W-1:0] cnt_reg;
    logic                 edge_hit;

    always_ff @(posedge i_ref_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            pin_reg <= 1'b0;
        else
            pin_reg <= ch.pin;
    end

    // Edge sampled on the clock; the input is already synchronous
    assign edge_hit = ch.pol ? (ch.pin & ~pin_reg) : (~ch.pin & pin_reg); // R9 R12
    assign ch.edge_hit = edge_hit & ch.en;

    always_ff @(posedge i_ref_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            cnt_reg <= EIT_CNT_RST; // R8
        else if (ch.en && edge_hit)
            cnt_reg <= EIT_CNT_RST; // R4 R12
        else if (ch.en)
            cnt_reg <= cnt_reg + EIT_CNT_ONE; // R3 R6
    end // R5: holds when disabled

    assign ch.count = cnt_reg;

    clear_wins_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // R12
        ch.edge_hit |=> cnt_reg == EIT_CNT_RST) else $error("edge did not clear");
    hold_off_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // R5
        !ch.en |=> $stable(cnt_reg)) else $error("counter moved while off");
    count_up_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // R3
        (ch.en && !edge_hit) |=> cnt_reg == $past(cnt_reg) + EIT_CNT_ONE)
        else $error("counter missed increment");
    wrap_zero_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // R6
        (ch.en && cnt_reg == 16'hFFFF) |=> cnt_reg == EIT_CNT_RST)
        else $error("counter did not wrap");
    wrap_c: cover property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        ch.en && cnt_reg == 16'hFFFF);
    edge_c: cover property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        ch.en ##1 ch.edge_hit);
endmodule : eit_chan

// file: eit_chan_if.sv
// Interface carrying one channel's control and counter between modules
`timescale 1ns/100ps
interface eit_chan_if;
    logic        en;
    logic        pol;
    logic        pin;
    logic        edge_hit;
    logic [15:0] count;
    modport ctl (output en, output pol, output pin, input edge_hit, input count);
    modport cnt (input en, input pol, input pin, output edge_hit, output count);
endinterface : eit_chan_if

// file: eit_pin_model.sv
// Far-side model: external pins and the CPU timer 1 request
`timescale 1ns/100ps
module eit_pin_model
(
    input  wire logic       i_ref_clk, // System clock
    input  wire logic [3:0] i_lvl,     // Wanted levels: irq1, irq2, nmi, timer1
    output logic      [3:0] o_pin      // Levels seen by the block
);
    // Pins move just after an edge, as a synchronous source would
    always_ff @(posedge i_ref_clk)
    begin
        o_pin <= i_lvl;
    end
endmodule : eit_pin_model

// file: eit_pkg.sv
// Package of constants and types for the external interrupt timestamp block
// Function
// R1: Enable and select set drive both lines
// R2: Separate 16-bit counter per external input
// R3: Counter increments each clock while enabled
// R4: Valid edge clears counter, counting resumes
// R5: Disabled input holds counter value
// R6: Counter wraps from maximum to zero
// R7: Counters read-only; writes never change them
// R8: Counters read zero after reset
// R9: Polarity 0 falling edge, 1 rising
// R10: Select routes timer 1 or pin
// R11: Enable blocks or passes pin to NMI
// R12: Edge clear wins over increment
package eit_pkg;
    localparam int          EIT_CNT_W         = 16;
    localparam int          EIT_NUM_CH        = 3;
    localparam int          EIT_ADDR_W        = 16;
    // Printed offsets are word indices; byte address is four times index
    localparam logic [15:0] EIT_IRQ1_CTL_IDX  = 16'h7070;
    localparam logic [15:0] EIT_IRQ2_CTL_IDX  = 16'h7071;
    localparam logic [15:0] EIT_NMI_CTL_IDX   = 16'h7077;
    localparam logic [15:0] EIT_IRQ1_TS_IDX   = 16'h7078;
    localparam logic [15:0] EIT_IRQ2_TS_IDX   = 16'h7079;
    localparam logic [15:0] EIT_NMI_TS_IDX    = 16'h707F;
    localparam int          EIT_EN_BIT        = 0;
    localparam int          EIT_SEL_BIT       = 1;
    localparam int          EIT_POL_BIT       = 2;
    localparam logic [2:0]  EIT_CTL_RST       = 3'h0;
    localparam logic [15:0] EIT_CNT_RST       = 16'h0000;
    localparam logic [15:0] EIT_CNT_ONE       = 16'h0001;
    localparam logic [31:0] EIT_RD_UNMAPPED   = 32'h00000000;
    typedef enum logic [1:0] {
        EIT_IDLE = 2'b00,
        EIT_ACK  = 2'b01
    } eit_bus_state_t;
endpackage : eit_pkg

// file: eit_top.sv
// Timestamp counters, interrupt routing and Avalon-MM register slave
//
// Decided for this implementation: the Avalon-MM interface to the registers.
`timescale 1ns/100ps
module eit_top
    import eit_pkg::*;
(
    input  wire logic        i_ref_clk,        // 20 MHz system clock
    input  wire logic        i_rst_n,          // Async reset, active low
    input  wire logic [15:0] i_avs_address,    // Word address (index)
    input  wire logic        i_avs_read,       // Read request
    input  wire logic        i_avs_write,      // Write request
    input  wire logic [31:0] i_avs_writedata,  // Write data
    input  wire logic [3:0]  i_avs_byteenable, // Byte enables
    output logic      [31:0] o_avs_readdata,   // Read data
    output logic             o_avs_waitrequest,// Wait request
    input  wire logic        i_ext_irq_one,    // External interrupt 1 pin
    input  wire logic        i_ext_irq_two,    // External interrupt 2 pin
    input  wire logic        i_ext_nmi_pin,    // External NMI / line 13 pin
    input  wire logic        i_cpu_timer1,     // CPU timer 1 request
    output logic             o_cpu_nmi,        // CPU NMI request
    output logic             o_cpu_line_13,    // CPU line 13 request
    output logic             o_irq1_edge,      // Valid edge pulse, irq 1
    output logic             o_irq2_edge,      // Valid edge pulse, irq 2
    output logic             o_nmi_edge        // Valid edge pulse, NMI
);
    logic [2:0]     ctl1_reg;
    logic [2:0]     ctl2_reg;
    logic [2:0]     ctln_reg;
    logic [31:0]    rdata_reg;
    logic [31:0]    rdata_next;
    eit_bus_state_t st_reg;
    logic           req;
    logic           take;

    eit_chan_if ch1 ();
    eit_chan_if ch2 ();
    eit_chan_if chn ();

    // Three independent counters, one per input
    eit_chan u_ch1 (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .ch(ch1)); // R2
    eit_chan u_ch2 (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .ch(ch2)); // R2
    eit_chan u_chn (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .ch(chn)); // R2

    assign ch1.en  = ctl1_reg[EIT_EN_BIT];
    assign ch1.pol = ctl1_reg[EIT_POL_BIT];
    assign ch1.pin = i_ext_irq_one;
    assign ch2.en  = ctl2_reg[EIT_EN_BIT];
    assign ch2.pol = ctl2_reg[EIT_POL_BIT];
    assign ch2.pin = i_ext_irq_two;
    assign chn.en  = ctln_reg[EIT_EN_BIT];
    assign chn.pol = ctln_reg[EIT_POL_BIT];
    assign chn.pin = i_ext_nmi_pin;

    assign o_irq1_edge = ch1.edge_hit;
    assign o_irq2_edge = ch2.edge_hit;
    assign o_nmi_edge  = chn.edge_hit;

    // Routing is a level path, so the CPU sees the pin with no added delay
    assign o_cpu_nmi     = ctln_reg[EIT_EN_BIT] & i_ext_nmi_pin; // R1 R11
    assign o_cpu_line_13 = ctln_reg[EIT_SEL_BIT] ? i_ext_nmi_pin : i_cpu_timer1; // R1 R10

    // One wait cycle per access keeps read data registered
    assign req               = i_avs_read | i_avs_write;
    assign take              = req && (st_reg == EIT_ACK);
    assign o_avs_waitrequest = req && (st_reg == EIT_IDLE);
    assign o_avs_readdata    = rdata_reg;

    always_ff @(posedge i_ref_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            st_reg <= EIT_IDLE;
        else
        begin
            unique case (st_reg)
                EIT_IDLE: st_reg <= req ? EIT_ACK : EIT_IDLE;
                EIT_ACK:  st_reg <= EIT_IDLE;
                default:  st_reg <= EIT_IDLE;
            endcase
        end
    end

    always_comb
    begin
        rdata_next = EIT_RD_UNMAPPED;
        unique case (i_avs_address)
            EIT_IRQ1_CTL_IDX: rdata_next = {29'h0, ctl1_reg[2], 1'b0, ctl1_reg[0]};
            EIT_IRQ2_CTL_IDX: rdata_next = {29'h0, ctl2_reg[2], 1'b0, ctl2_reg[0]};
            EIT_NMI_CTL_IDX:  rdata_next = {29'h0, ctln_reg};
            EIT_IRQ1_TS_IDX:  rdata_next = {16'h0, ch1.count};
            EIT_IRQ2_TS_IDX:  rdata_next = {16'h0, ch2.count};
            EIT_NMI_TS_IDX:   rdata_next = {16'h0, chn.count};
            default:          rdata_next = EIT_RD_UNMAPPED;
        endcase
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            rdata_reg <= 32'h00000000;
        else if (i_avs_read && st_reg == EIT_IDLE)
            rdata_reg <= rdata_next;
    end

    // Counter offsets are not decoded for writes, so software cannot touch them
    always_ff @(posedge i_ref_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            ctl1_reg <= EIT_CTL_RST;
            ctl2_reg <= EIT_CTL_RST;
            ctln_reg <= EIT_CTL_RST;
        end
        else if (take && i_avs_write && i_avs_byteenable[0])
        begin
            unique case (i_avs_address) // R7
                EIT_IRQ1_CTL_IDX: ctl1_reg <= {i_avs_writedata[2], 1'b0, i_avs_writedata[0]};
                EIT_IRQ2_CTL_IDX: ctl2_reg <= {i_avs_writedata[2], 1'b0, i_avs_writedata[0]};
                EIT_NMI_CTL_IDX:  ctln_reg <= i_avs_writedata[2:0];
                default:          ctln_reg <= ctln_reg;
            endcase
        end
    end

    nmi_route_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // R1
        (ctln_reg[EIT_EN_BIT] && ctln_reg[EIT_SEL_BIT])
        |-> (o_cpu_nmi == i_ext_nmi_pin && o_cpu_line_13 == i_ext_nmi_pin))
        else $error("pin not routed to both lines");
    nmi_block_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // R11
        !ctln_reg[EIT_EN_BIT] |-> !o_cpu_nmi) else $error("NMI not blocked");
    line13_timer_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // R10
        !ctln_reg[EIT_SEL_BIT] |-> o_cpu_line_13 == i_cpu_timer1)
        else $error("line 13 not from timer");
    // Covers a write while counting too: the count must only advance normally
    ts_write_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // R7
        (take && i_avs_write && i_avs_address == EIT_IRQ1_TS_IDX && !ch1.edge_hit)
        |=> ch1.count == ($past(ch1.en) ? $past(ch1.count) + EIT_CNT_ONE : $past(ch1.count)))
        else $error("write changed counter");
    bus_wait_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        ($rose(req) && st_reg == EIT_IDLE) |-> o_avs_waitrequest ##1 !o_avs_waitrequest)
        else $error("access not answered in one cycle");
    rd_ts_c: cover property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        take && i_avs_read && i_avs_address == EIT_NMI_TS_IDX);
    both_c: cover property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        ctln_reg == 3'h3 && i_ext_nmi_pin);
endmodule : eit_top

// file: eit_top_bench.sv
// Self-checking bench for timestamp counters and interrupt routing
`timescale 1ns/100ps
module eit_top_bench
    import eit_pkg::*;
;
    logic        clk = 1'b0, rst_n = 1'b0, rd = 1'b0, wr = 1'b0;
    logic [15:0] addr = 16'h0000;
    logic [31:0] wdata = 32'h00000000, rdata, q;
    logic [3:0]  lvl = 4'h0, pin;
    logic [2:0]  edge_p;
    logic        wait_req, nmi, l13;
    logic [15:0] va;
    logic [15:0] regs [7];
    int          num_errors = 0, n_tests = 0, cyc = 0, ta, tb;

    eit_top dut (.i_ref_clk(clk), .i_rst_n(rst_n), .i_avs_address(addr), .i_avs_read(rd),
        .i_avs_write(wr), .i_avs_writedata(wdata), .i_avs_byteenable(4'hF),
        .o_avs_readdata(rdata), .o_avs_waitrequest(wait_req), .i_ext_irq_one(pin[0]),
        .i_ext_irq_two(pin[1]), .i_ext_nmi_pin(pin[2]), .i_cpu_timer1(pin[3]),
        .o_cpu_nmi(nmi), .o_cpu_line_13(l13), .o_irq1_edge(edge_p[0]),
        .o_irq2_edge(edge_p[1]), .o_nmi_edge(edge_p[2]));
    eit_pin_model far (.i_ref_clk(clk), .i_lvl(lvl), .o_pin(pin));

    initial
    begin
        forever #25 clk = ~clk;
    end
    always @(posedge clk) cyc <= cyc + 1;

    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : complete_run

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            num_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // One bus access; t is the cycle of the answer, so differences of t are exact
    task automatic bus(input logic w, input logic [15:0] a, input logic [31:0] d,
                       output logic [31:0] r, output int t);
        @(posedge clk);
        rd    <= ~w;
        wr    <= w;
        addr  <= a;
        wdata <= d;
        // Outputs move only on clock edges, so values read here are those the edge samples
        repeat (20)
        begin
            @(posedge clk);
            if (wait_req === 1'b0) break;
        end
        if (wait_req !== 1'b0)
        begin
            num_errors++;
            complete_run();
        end
        else
        begin
            r = rdata;
            t = cyc;
            rd <= 1'b0;
            wr <= 1'b0;
        end
    endtask : bus

    initial
    begin
        regs = '{EIT_IRQ1_TS_IDX, EIT_IRQ2_TS_IDX, EIT_NMI_TS_IDX, EIT_IRQ1_CTL_IDX,
                 EIT_IRQ2_CTL_IDX, EIT_NMI_CTL_IDX, 16'h7072};
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 7; i++)
        begin
            bus(1'b0, regs[i], 32'h00000000, q, ta);
            chk(q, 32'h00000000);
        end
        lvl <= 4'h3;
        bus(1'b1, EIT_IRQ1_CTL_IDX, 32'h00000001, q, ta);
        bus(1'b0, EIT_IRQ1_TS_IDX, 32'h00000000, q, ta);
        va = q[15:0];
        bus(1'b1, EIT_IRQ1_TS_IDX, 32'h0000FFFF, q, tb);
        bus(1'b0, EIT_IRQ1_TS_IDX, 32'h00000000, q, tb);
        chk(q, {16'h0000, va + 16'(tb - ta)});
        // Both pins fall together; only the enabled channel may react
        @(posedge clk);
        lvl <= 4'h0;
        @(posedge clk);
        @(negedge clk);
        chk({29'h0, edge_p}, 32'h00000001);
        bus(1'b0, EIT_IRQ1_TS_IDX, 32'h00000000, q, ta);
        chk(32'(q < 32'h00000010), 32'h00000001);
        bus(1'b0, EIT_IRQ2_TS_IDX, 32'h00000000, q, ta);
        chk(q, 32'h00000000);
        bus(1'b1, EIT_IRQ2_CTL_IDX, 32'h00000005, q, ta);
        for (int p = 1; p >= 0; p--)
        begin
            @(posedge clk);
            lvl[1] <= p[0];
            @(posedge clk);
            @(negedge clk);
            chk({29'h0, edge_p}, {29'h0, 1'b0, p[0], 1'b0});
        end
        bus(1'b0, EIT_IRQ2_TS_IDX, 32'h00000000, q, ta);
        va = q[15:0];
        // Long enough to pass the top of the count once
        repeat (65540) @(posedge clk);
        bus(1'b0, EIT_IRQ2_TS_IDX, 32'h00000000, q, tb);
        chk(q, {16'h0000, va + 16'(tb - ta)});
        for (int m = 0; m < 4; m++)
        begin
            bus(1'b1, EIT_NMI_CTL_IDX, 32'(m), q, ta);
            for (int p = 0; p < 2; p++)
            begin
                @(posedge clk);
                lvl <= {~p[0], p[0], 2'b00};
                @(posedge clk);
                @(negedge clk);
                chk({nmi, l13}, {m[0] & p[0], m[1] ? p[0] : ~p[0]});
            end
        end
        complete_run();
    end
endmodule : eit_top_bench
